// *** hdl/dsra_top.sv ***
// dual i2c / spi slave front end giving a host access to the register index space
// What this block does
// R1 - chip select high enables i2c, low spi
// R2 - target address 101110 plus strap pin
// R3 - compare seven address bits, eighth is direction
// R4 - receiver drives acknowledge low on ninth clock
// R5 - byte after address is register pointer
// R6 - auto increment advances pointer per byte
// R7 - host sets pointer msb for incrementing reads
// R8 - host reads via repeated start sequence
// R9 - write: address, pointer, data bytes, all acknowledged
// R10 - msb first bytes, unlimited, stop ends
// R11 - receiver may hold clock low to stall
// R12 - unmatched address leaves data line high
// R13 - works at standard and 400 kHz rates
// R14 - spi host frames with chip select low
// R15 - spi drives on falling, samples rising
// R16 - spi frame 16 clocks, plus 8 per further byte
// R17 - first spi bit selects read or write
// R18 - bits 1-7 index, then data msb first
// R19 - spi read drives output from bit 8
// R20 - spi bursts reuse or increment index
// R21 - three wire mode reads on shared pin
// R22 - three wire mode supports burst reads
// R23 - increment wraps last output to first
// R24 - ignore foreign traffic, keep data released
`timescale 1ns/1ps

module dsra_top
    import dsra_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic serial_port_clock,
    input wire logic cs_pin,
    input wire logic sda_sdi_in,
    input wire logic scl_in,
    input wire logic addr_lsb_strap,
    input wire logic three_wire_select,
    input wire logic auto_increment,
    input wire logic reg_busy,
    input wire logic [7:0] reg_rd_data,
    output logic [6:0] reg_index_q,
    output logic reg_wr_q,
    output logic reg_rd_q,
    output logic [7:0] write_byte_q,
    output logic sda_out_q,
    output logic sda_oe_q,
    output logic scl_out_q,
    output logic scl_oe_q,
    output logic sdo_q,
    output logic sdo_oe_q,
    output logic sdio_oe_q
);

    // ****************************************
    // pin synchronisers, system clock side
    // ****************************************
    // order: cs, scl, sda, strap; 40 MHz gives 100 samples per 400 kHz bit
    logic [3:0] pin_m_q;
    logic [3:0] pin_s_q;
    logic scl_p_q;
    logic sda_p_q;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            pin_m_q <= 4'hF;
            pin_s_q <= 4'hF;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end
        else
        begin
            pin_m_q <= {cs_pin, scl_in, sda_sdi_in, addr_lsb_strap}; // R13
            pin_s_q <= pin_m_q;
            scl_p_q <= pin_s_q[2];
            sda_p_q <= pin_s_q[1];
        end
    end

    wire cs_s = pin_s_q[3];
    wire scl_s = pin_s_q[2];
    wire sda_s = pin_s_q[1];
    wire strap_s = pin_s_q[0];
    wire scl_rise = scl_s & ~scl_p_q;
    wire scl_fall = ~scl_s & scl_p_q;
    wire start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
    wire stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;

    // ****************************************
    // spi link, serial_port_clock domain
    // ****************************************
    // frame logic is cleared while chip select is high, so no edge
    // outside a frame is needed
    wire spi_rst_n = rstn & ~cs_pin; // R14
    logic [3:0] bit_q;
    logic [6:0] in_q;
    dsra_cmd_t cmd_q;
    logic [7:0] spi_byte_q;
    logic cmd_tg_q;
    logic byte_tg_q;
    logic tw_m_q;
    logic tw_s_q;
    logic [7:0] out_q;
    logic [7:0] hold_q;

    // after bit 15 the counter loops over 8..15 for further blocks
    wire [3:0] bit_d = (bit_q == SPI_BLOCK_LAST) ? SPI_DATA_FIRST : bit_q + 4'h1; // R16
    wire cmd_cap = (bit_q == SPI_CMD_LAST);
    wire byte_cap = bit_q[3] & (bit_q[2:0] == SPI_SLOT_LAST);
    wire [7:0] sh_in = {in_q, sda_sdi_in};

    always_ff @(posedge serial_port_clock or negedge spi_rst_n)
    begin
        if (!spi_rst_n)
        begin
            bit_q <= 4'h0;
            in_q <= 7'h00;
        end
        else
        begin
            bit_q <= bit_d;
            in_q <= sh_in[6:0]; // R15
        end
    end

    // captured words survive chip select rising so the last byte is not lost
    always_ff @(posedge serial_port_clock or negedge rstn)
    begin
        if (!rstn)
        begin
            cmd_q <= '0;
            spi_byte_q <= BYTE_RST;
            cmd_tg_q <= 1'b0;
            byte_tg_q <= 1'b0;
            tw_m_q <= 1'b0;
            tw_s_q <= 1'b0;
        end
        else
        begin
            tw_m_q <= three_wire_select;
            tw_s_q <= tw_m_q;
            if (cmd_cap)
            begin
                cmd_q <= sh_in; // R17 R18
                cmd_tg_q <= ~cmd_tg_q;
            end
            if (byte_cap)
            begin
                spi_byte_q <= sh_in; // R18
                byte_tg_q <= ~byte_tg_q;
            end
        end
    end

    wire spi_drive = cmd_q.rd & bit_q[3];
    wire slot_first = (bit_q[2:0] == SPI_SLOT_FIRST);

    // hold_q is refreshed by the system side between blocks and is
    // quiet when sampled here
    always_ff @(negedge serial_port_clock or negedge spi_rst_n)
    begin
        if (!spi_rst_n)
        begin
            out_q <= BYTE_RST;
            sdo_q <= 1'b0;
            sdo_oe_q <= 1'b0;
            sdio_oe_q <= 1'b0;
        end
        else
        begin
            out_q <= slot_first ? hold_q : {out_q[6:0], 1'b0};
            sdo_q <= slot_first ? hold_q[7] : out_q[6]; // R15 R19
            sdo_oe_q <= spi_drive & ~tw_s_q; // R19
            sdio_oe_q <= spi_drive & tw_s_q; // R21 R22
        end
    end

    // ****************************************
    // event crossing into the system clock
    // ****************************************
    logic [2:0] cmd_sy_q;
    logic [2:0] byte_sy_q;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            cmd_sy_q <= 3'h0;
            byte_sy_q <= 3'h0;
        end
        else
        begin
            cmd_sy_q <= {cmd_sy_q[1:0], cmd_tg_q};
            byte_sy_q <= {byte_sy_q[1:0], byte_tg_q};
        end
    end

    wire cmd_ev = cmd_sy_q[2] ^ cmd_sy_q[1];
    wire byte_ev = byte_sy_q[2] ^ byte_sy_q[1];

    // ****************************************
    // register access and i2c engine
    // ****************************************
    dsra_i2c_st_t ist_q, ist_d;
    dsra_kind_t kind_q, kind_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] rx_q, rx_d;
    logic [7:0] tx_q, tx_d;
    logic rd_dir_q, rd_dir_d;
    logic acked_q, acked_d;
    logic inc_q, inc_d;
    logic spi_rd_q, spi_rd_d;
    logic load_q, load_d;
    logic [7:0] hold_d;
    logic [6:0] idx_d;
    logic wr_d, rd_d, sda_oe_d, scl_oe_d;
    logic [7:0] byte_d;

    wire addr_match = (rx_q[7:1] == {TGT_ADDR_HI, strap_s}); // R2 R3
    wire byte_end = scl_fall & (cnt_q == I2C_BYTE_BITS);
    wire [6:0] idx_next = dsra_next_idx(reg_index_q, inc_q); // R6 R23
    wire [6:0] spi_next = dsra_next_idx(reg_index_q, auto_increment); // R20 R23

    always_comb
    begin
        ist_d = ist_q;
        kind_d = kind_q;
        cnt_d = cnt_q;
        rx_d = rx_q;
        tx_d = tx_q;
        rd_dir_d = rd_dir_q;
        acked_d = acked_q;
        inc_d = inc_q;
        spi_rd_d = spi_rd_q;
        load_d = 1'b0;
        hold_d = hold_q;
        idx_d = reg_index_q;
        wr_d = 1'b0;
        rd_d = 1'b0;
        byte_d = write_byte_q;
        sda_oe_d = sda_oe_q;
        scl_oe_d = 1'b0;
        // spi side: command sets index, each block writes or prefetches
        if (cmd_ev)
        begin
            idx_d = cmd_q.idx; // R18
            spi_rd_d = cmd_q.rd; // R17
            load_d = cmd_q.rd;
        end
        if (load_q)
        begin
            hold_d = reg_rd_data; // R19
            rd_d = 1'b1;
        end
        if (byte_ev)
        begin
            wr_d = ~spi_rd_q;
            byte_d = spi_rd_q ? write_byte_q : spi_byte_q;
            idx_d = spi_rd_q ? spi_next : reg_index_q; // R20
            load_d = spi_rd_q; // R22
        end
        // a written block moves the index only after its strobe went out
        if (reg_wr_q && !cs_s)
            idx_d = spi_next; // R20
        if (!cs_s)
        begin
            ist_d = DSRA_IDLE; // R1
            sda_oe_d = 1'b0;
        end
        else if (start_c)
        begin
            // start and repeated start both restart address reception
            ist_d = DSRA_RX; // R3
            kind_d = DSRA_K_ADDR;
            cnt_d = 4'h0;
            sda_oe_d = 1'b0;
        end
        else if (stop_c)
        begin
            ist_d = DSRA_IDLE; // R10
            sda_oe_d = 1'b0;
        end
        else
        begin
            case (ist_q)
                DSRA_RX:
                begin
                    if (scl_rise)
                    begin
                        rx_d = {rx_q[6:0], sda_s}; // R10
                        cnt_d = cnt_q + 4'h1;
                    end
                    // stall the host while the register side is busy
                    if (kind_q == DSRA_K_DATA && cnt_q == 4'h0 && !scl_s && reg_busy)
                        scl_oe_d = 1'b1; // R11
                    if (byte_end)
                    begin
                        cnt_d = 4'h0;
                        sda_oe_d = 1'b1; // R4 R9
                        ist_d = DSRA_RACK;
                        case (kind_q)
                            DSRA_K_ADDR:
                            begin
                                rd_dir_d = rx_q[0]; // R3
                                if (!addr_match)
                                begin
                                    sda_oe_d = 1'b0; // R12 R24
                                    ist_d = DSRA_IDLE;
                                end
                            end
                            DSRA_K_SUB:
                            begin
                                idx_d = rx_q[6:0]; // R5
                                inc_d = rx_q[7] | auto_increment; // R6 R7
                            end
                            default:
                            begin
                                wr_d = 1'b1; // R9
                                byte_d = rx_q;
                            end
                        endcase
                    end
                end
                DSRA_RACK:
                begin
                    if (scl_fall)
                    begin
                        cnt_d = 4'h0;
                        sda_oe_d = 1'b0; // R4
                        if (kind_q == DSRA_K_ADDR && rd_dir_q)
                        begin
                            tx_d = reg_rd_data; // R8
                            rd_d = 1'b1;
                            sda_oe_d = ~reg_rd_data[7];
                            ist_d = DSRA_TX;
                        end
                        else
                        begin
                            ist_d = DSRA_RX;
                            kind_d = (kind_q == DSRA_K_ADDR) ? DSRA_K_SUB : DSRA_K_DATA;
                            if (kind_q == DSRA_K_DATA)
                                idx_d = idx_next; // R6
                        end
                    end
                end
                DSRA_TX:
                begin
                    if (scl_fall)
                    begin
                        cnt_d = cnt_q + 4'h1;
                        tx_d = {tx_q[6:0], 1'b0};
                        sda_oe_d = ~tx_q[6]; // R10
                        if (cnt_q == I2C_TX_LAST)
                        begin
                            sda_oe_d = 1'b0; // R4
                            ist_d = DSRA_TACK;
                        end
                    end
                end
                DSRA_TACK:
                begin
                    if (scl_rise)
                    begin
                        acked_d = ~sda_s; // R8
                        if (!sda_s)
                            idx_d = idx_next; // R6 R23
                    end
                    if (scl_fall)
                    begin
                        cnt_d = 4'h0;
                        ist_d = acked_q ? DSRA_TX : DSRA_IDLE; // R8
                        if (acked_q)
                        begin
                            tx_d = reg_rd_data;
                            rd_d = 1'b1;
                            sda_oe_d = ~reg_rd_data[7];
                        end
                    end
                end
                default:
                begin
                    ist_d = DSRA_IDLE; // R24
                    sda_oe_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            ist_q <= DSRA_IDLE;
            kind_q <= DSRA_K_ADDR;
            cnt_q <= 4'h0;
            rx_q <= BYTE_RST;
            tx_q <= BYTE_RST;
            rd_dir_q <= 1'b0;
            acked_q <= 1'b0;
            inc_q <= 1'b0;
        end
        else
        begin
            ist_q <= ist_d;
            kind_q <= kind_d;
            cnt_q <= cnt_d;
            rx_q <= rx_d;
            tx_q <= tx_d;
            rd_dir_q <= rd_dir_d;
            acked_q <= acked_d;
            inc_q <= inc_d;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            spi_rd_q <= 1'b0;
            load_q <= 1'b0;
            hold_q <= BYTE_RST;
            reg_index_q <= IDX_RST;
            reg_wr_q <= 1'b0;
            reg_rd_q <= 1'b0;
            write_byte_q <= BYTE_RST;
            sda_out_q <= 1'b0;
            sda_oe_q <= 1'b0;
            scl_out_q <= 1'b0;
            scl_oe_q <= 1'b0;
        end
        else
        begin
            spi_rd_q <= spi_rd_d;
            load_q <= load_d;
            hold_q <= hold_d;
            reg_index_q <= idx_d;
            reg_wr_q <= wr_d;
            reg_rd_q <= rd_d;
            write_byte_q <= byte_d;
            sda_oe_q <= sda_oe_d;
            scl_oe_q <= scl_oe_d;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    sequence s_addr_ok;
        ist_q == DSRA_RX && kind_q == DSRA_K_ADDR && byte_end && addr_match && cs_s && !start_c && !stop_c;
    endsequence

    sequence s_ack_phase;
        (sda_oe_q && ist_q == DSRA_RACK)[*2];
    endsequence

    a_spi_only_mode: assert property (!cs_s |=> ist_q == DSRA_IDLE && !sda_oe_q) // R1
        else $error("i2c engine active while chip select low");

    a_addr_ack: assert property (s_addr_ok |=> s_ack_phase) // R2 R4
        else $error("matching address not acknowledged");

    a_foreign_quiet: assert property (ist_q == DSRA_RX && kind_q == DSRA_K_ADDR && byte_end
        && !addr_match && cs_s && !start_c && !stop_c |=> ist_q == DSRA_IDLE && !sda_oe_q) // R12
        else $error("unmatched address not ignored");

    a_idle_released: assert property (ist_q == DSRA_IDLE |-> !sda_oe_q) // R24
        else $error("data line driven while idle");

    a_ptr_load: assert property (ist_q == DSRA_RX && kind_q == DSRA_K_SUB && byte_end
        && cs_s && !start_c && !stop_c && !cmd_ev && !byte_ev |=> reg_index_q == $past(rx_q[6:0])) // R5
        else $error("register pointer not taken from sub byte");

    a_spi_wrap: assert property (((byte_ev && spi_rd_q) || (reg_wr_q && !cs_s)) && auto_increment
        && reg_index_q == OUT_LAST && !cmd_ev |=> reg_index_q == OUT_FIRST) // R23
        else $error("burst index did not wrap");

    a_spi_fixed: assert property (byte_ev && !auto_increment && !cmd_ev
        && !(cs_s && ist_q != DSRA_IDLE) |=> $stable(reg_index_q)) // R20
        else $error("index moved with increment off");

    a_spi_write: assert property (byte_ev && !spi_rd_q |=> reg_wr_q ##1 !reg_wr_q) // R17 R9
        else $error("spi write block gave no single write strobe");

    a_spi_prefetch: assert property (byte_ev && spi_rd_q |=> ##1 reg_rd_q) // R19
        else $error("next read byte not fetched");

    a_read_pin: assert property (@(negedge serial_port_clock) disable iff (!spi_rst_n)
        (sdo_oe_q || sdio_oe_q) |-> cmd_q.rd && !(sdo_oe_q && sdio_oe_q)) // R19 R21
        else $error("spi output driven outside a read");

endmodule : dsra_top

// *** shared/dsra_pkg.sv ***
// constants, types and helpers shared by the serial register access block
package dsra_pkg;

    // upper six bits of the bus target address
    localparam logic [5:0] TGT_ADDR_HI = 6'h2E;
    // output register window walked by incrementing reads
    localparam logic [6:0] OUT_FIRST = 7'h28;
    localparam logic [6:0] OUT_LAST = 7'h2C;
    // bits per byte on the i2c link
    localparam logic [3:0] I2C_BYTE_BITS = 4'h8;
    localparam logic [3:0] I2C_TX_LAST = 4'h7;
    // spi frame: command bits 0..7, data blocks from bit 8 on
    localparam logic [3:0] SPI_CMD_LAST = 4'h7;
    localparam logic [3:0] SPI_DATA_FIRST = 4'h8;
    localparam logic [3:0] SPI_BLOCK_LAST = 4'hF;
    localparam logic [2:0] SPI_SLOT_LAST = 3'h7;
    localparam logic [2:0] SPI_SLOT_FIRST = 3'h0;
    // reset values
    localparam logic [6:0] IDX_RST = 7'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;

    typedef enum logic [2:0]
    {
        DSRA_IDLE = 3'h0,
        DSRA_RX = 3'h1,
        DSRA_RACK = 3'h3,
        DSRA_TX = 3'h2,
        DSRA_TACK = 3'h6
    } dsra_i2c_st_t;

    typedef enum logic [1:0]
    {
        DSRA_K_ADDR = 2'h0,
        DSRA_K_SUB = 2'h1,
        DSRA_K_DATA = 2'h3
    } dsra_kind_t;

    // spi command byte as it arrives: direction first, then index
    typedef struct packed
    {
        logic rd;
        logic [6:0] idx;
    } dsra_cmd_t;

    function automatic logic [6:0] dsra_next_idx(input logic [6:0] idx, input logic inc);
        if (!inc)
            return idx;
        else if (idx == OUT_LAST)
            return OUT_FIRST;
        else
            return idx + 7'h01;
    endfunction : dsra_next_idx

endpackage : dsra_pkg

// *** tb/dsra_host_model.sv ***
// host master model driving the shared i2c / spi pads
`timescale 1ns/1ps

module dsra_host_model
(
    output logic cs_pin,
    output logic clk_drv,
    output logic sda_drv,
    input wire logic scl_line,
    input wire logic sda_line,
    input wire logic miso
);
    // spi half period well above the cross-domain margin
    localparam time SPI_H = 200ns;
    // 400 kHz i2c
    localparam time I2C_H = 1250ns;

    initial
    begin
        cs_pin = 1'b1;
        clk_drv = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic spi_xfer(input logic [7:0] cmd, input logic [7:0] wd0, input logic [7:0] wd1,
        input int n, output logic [7:0] rd0, output logic [7:0] rd1);
        logic [23:0] tx;
        logic [23:0] rx;
        tx = {cmd, wd0, wd1};
        rx = '0;
        cs_pin = 1'b0;
        #(SPI_H);
        for (int i = 0; i < 8 + 8 * n; i++)
        begin
            clk_drv = 1'b0;
            // released data pin toggles so a stale level never reads back
            sda_drv = (cmd[7] && i >= 8) ? ~sda_drv : tx[23 - i];
            #(SPI_H);
            clk_drv = 1'b1;
            rx[23 - i] = miso;
            #(SPI_H);
        end
        cs_pin = 1'b1;
        rd0 = rx[15:8];
        rd1 = rx[7:0];
        #(SPI_H);
    endtask : spi_xfer

    task automatic i2c_clock(input logic bit_out, output logic bit_in);
        int w;
        #(I2C_H / 4);
        sda_drv = bit_out;
        #(3 * I2C_H / 4);
        clk_drv = 1'b1;
        w = 0;
        // a stretching target holds the clock low
        while (!scl_line && w < 4000)
        begin
            #10ns;
            w++;
        end
        #(I2C_H / 2);
        bit_in = sda_line;
        #(I2C_H / 2);
        clk_drv = 1'b0;
    endtask : i2c_clock

    task automatic i2c_byte(input logic [7:0] b, output logic ack_n);
        logic d;
        for (int i = 7; i >= 0; i--)
            i2c_clock(b[i], d);
        i2c_clock(1'b1, ack_n);
    endtask : i2c_byte

    task automatic i2c_read(input logic host_ack_n, output logic [7:0] b);
        logic d;
        for (int i = 7; i >= 0; i--)
            i2c_clock(1'b1, b[i]);
        i2c_clock(host_ack_n, d);
    endtask : i2c_read

    task automatic i2c_start();
        #(I2C_H / 4);
        sda_drv = 1'b1;
        #(I2C_H);
        clk_drv = 1'b1;
        #(I2C_H);
        sda_drv = 1'b0;
        #(I2C_H);
        clk_drv = 1'b0;
    endtask : i2c_start

    task automatic i2c_stop();
        #(I2C_H / 4);
        sda_drv = 1'b0;
        #(I2C_H);
        clk_drv = 1'b1;
        #(I2C_H);
        sda_drv = 1'b1;
        #(I2C_H);
    endtask : i2c_stop

endmodule : dsra_host_model

// *** tb/test_dual_serial_register_access.sv ***
// self-checking bench of the dual serial register access block
`timescale 1ns/1ps
`define CHK(name, exp, got) check_val(name, 8'(exp), 8'(got))

module test_dual_serial_register_access;
    import dsra_pkg::*;

    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic auto_increment = 1'b1;
    logic three_wire_select = 1'b0;
    logic addr_lsb_strap = 1'b1;
    logic cs_pin, clk_drv, sda_drv;
    logic [6:0] reg_index_q;
    logic reg_wr_q, reg_rd_q, sda_out_q, sda_oe_q, scl_out_q, scl_oe_q, sdo_q, sdo_oe_q, sdio_oe_q;
    logic [7:0] write_byte_q;
    logic [7:0] reg_rd_data;
    logic scl_line, sda_line, sda_sdi_in, sdo_pin, miso;
    int errors = 0;
    int total_checks = 0;
    int wr_cnt = 0;
    int rd_cnt = 0;
    int stretch_cnt = 0;
    // register side is busy only for the first 80 stretched cycles
    wire reg_busy = (stretch_cnt < 80);
    logic [6:0] wr_idx = 7'h00;
    logic [7:0] wr_byte = 8'h00;
    logic [7:0] r0, r1;
    logic a0, a1, a2, a3;

    always #12.5 clk_sys = ~clk_sys;

    // ************************************************************
    // pads and register side
    // ************************************************************
    function automatic logic [7:0] reg_val(input logic [6:0] idx);
        return {1'b1, idx} ^ 8'h3C;
    endfunction : reg_val

    assign scl_line = clk_drv & ~scl_oe_q;
    assign sda_line = sda_drv & ~sda_oe_q;
    assign sda_sdi_in = sdio_oe_q ? sdo_q : sda_line;
    // undriven sdo shows the wrong level on purpose
    assign sdo_pin = sdo_oe_q ? sdo_q : ~sdo_q;
    assign miso = three_wire_select ? sda_sdi_in : sdo_pin;
    assign reg_rd_data = reg_val(reg_index_q);

    dsra_host_model host (.cs_pin(cs_pin), .clk_drv(clk_drv), .sda_drv(sda_drv),
        .scl_line(scl_line), .sda_line(sda_line), .miso(miso));

    dsra_top uut (.clk_sys(clk_sys), .rstn(rstn), .serial_port_clock(scl_line), .cs_pin(cs_pin),
        .sda_sdi_in(sda_sdi_in), .scl_in(scl_line), .addr_lsb_strap(addr_lsb_strap),
        .three_wire_select(three_wire_select), .auto_increment(auto_increment), .reg_busy(reg_busy),
        .reg_rd_data(reg_rd_data), .reg_index_q(reg_index_q), .reg_wr_q(reg_wr_q), .reg_rd_q(reg_rd_q),
        .write_byte_q(write_byte_q), .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q), .scl_out_q(scl_out_q),
        .scl_oe_q(scl_oe_q), .sdo_q(sdo_q), .sdo_oe_q(sdo_oe_q), .sdio_oe_q(sdio_oe_q));

    always @(posedge clk_sys)
    begin
        if (reg_wr_q === 1'b1)
        begin
            wr_cnt <= wr_cnt + 1;
            wr_idx <= reg_index_q;
            wr_byte <= write_byte_q;
        end
        if (reg_rd_q === 1'b1)
            rd_cnt <= rd_cnt + 1;
        if (scl_oe_q === 1'b1)
            stretch_cnt <= stretch_cnt + 1;
    end

    // ************************************************************
    // checking and closing
    // ************************************************************
    task automatic check_val(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check_val

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    task automatic set_mode(input logic inc, input logic three);
        @(posedge clk_sys);
        #2;
        auto_increment = inc;
        three_wire_select = three;
    endtask : set_mode

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_spi_write();
        int c;
        set_mode(1'b1, 1'b0);
        c = wr_cnt;
        host.spi_xfer({1'b0, 7'h12}, 8'h5A, 8'hC3, 2, r0, r1);
        repeat (8) @(posedge clk_sys);
        `CHK("spi write count", 2, wr_cnt - c);
        `CHK("spi write index", 7'h13, wr_idx);
        `CHK("spi write byte", 8'hC3, wr_byte);
    endtask : t_spi_write

    task automatic t_spi_read_wrap();
        set_mode(1'b1, 1'b0);
        host.spi_xfer({1'b1, 7'h2C}, 8'h00, 8'h00, 2, r0, r1);
        `CHK("spi read first", reg_val(7'h2C), r0);
        `CHK("spi read wrap", reg_val(7'h28), r1);
    endtask : t_spi_read_wrap

    task automatic t_spi_three_wire();
        set_mode(1'b0, 1'b1);
        host.spi_xfer({1'b1, 7'h05}, 8'h00, 8'h00, 2, r0, r1);
        `CHK("3w read first", reg_val(7'h05), r0);
        `CHK("3w read same index", reg_val(7'h05), r1);
        set_mode(1'b1, 1'b0);
    endtask : t_spi_three_wire

    task automatic t_i2c_write();
        int c;
        set_mode(1'b1, 1'b0);
        c = wr_cnt;
        host.i2c_start();
        host.i2c_byte({6'h2E, addr_lsb_strap, 1'b0}, a0);
        host.i2c_byte(8'h20, a1);
        host.i2c_byte(8'hA5, a2);
        host.i2c_byte(8'h3C, a3);
        host.i2c_stop();
        `CHK("i2c addr ack", 0, a0);
        `CHK("i2c sub ack", 0, a1);
        `CHK("i2c data acks", 0, a2 | a3);
        `CHK("i2c write count", 2, wr_cnt - c);
        `CHK("i2c write index", 7'h21, wr_idx);
        `CHK("i2c write byte", 8'h3C, wr_byte);
        `CHK("i2c stretch cycles", 81, stretch_cnt);
    endtask : t_i2c_write

    task automatic t_i2c_read();
        int c;
        set_mode(1'b0, 1'b0);
        c = rd_cnt;
        host.i2c_start();
        host.i2c_byte({6'h2E, addr_lsb_strap, 1'b0}, a0);
        host.i2c_byte(8'hAB, a1);
        host.i2c_start();
        host.i2c_byte({6'h2E, addr_lsb_strap, 1'b1}, a2);
        host.i2c_read(1'b0, r0);
        host.i2c_read(1'b1, r1);
        host.i2c_stop();
        `CHK("i2c read acks", 0, a0 | a1 | a2);
        `CHK("i2c read first", reg_val(7'h2B), r0);
        `CHK("i2c read incremented", reg_val(7'h2C), r1);
        `CHK("i2c read pops", 2, rd_cnt - c);
        set_mode(1'b1, 1'b0);
    endtask : t_i2c_read

    task automatic t_i2c_foreign();
        int c;
        c = wr_cnt;
        host.i2c_start();
        host.i2c_byte({6'h2E, ~addr_lsb_strap, 1'b0}, a0);
        host.i2c_byte(8'h10, a1);
        host.i2c_byte(8'h77, a2);
        host.i2c_stop();
        `CHK("foreign addr ack", 1, a0);
        `CHK("foreign bytes released", 1, a1 & a2);
        `CHK("foreign write count", 0, wr_cnt - c);
    endtask : t_i2c_foreign

    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial
    begin
        repeat (2) @(posedge clk_sys);
        #2;
        rstn = 1'b1;
        repeat (6) @(posedge clk_sys);
        `CHK("idle after reset", 0, {reg_index_q, sda_oe_q});
        `CHK("pad out levels", 0, {sda_out_q, scl_out_q, scl_oe_q, sdo_oe_q, sdio_oe_q});
        t_spi_write();
        t_spi_read_wrap();
        t_spi_three_wire();
        t_i2c_write();
        t_i2c_read();
        t_i2c_foreign();
        report_and_stop();
    end

    // whole run needs about a third of a millisecond
    initial
    begin
        #2ms;
        errors++;
        report_and_stop();
    end

endmodule : test_dual_serial_register_access
